// ==== shared/wdog_pkg.sv ====
// watchdog reset/reload-lock package: register indices, unlock codes,
// lock states, reset-cause layout, timing constants.
// assumes a byte-wide register port from the processor core.
package wdog_pkg;

  // ************************************************************
  // register selection and unlock pattern
  // ************************************************************
  localparam logic [1:0] sel_control_port = 2'h0; // control / reset cause
  localparam logic [1:0] sel_upper        = 2'h1; // reload upper byte
  localparam logic [1:0] sel_high         = 2'h2; // reload high byte
  localparam logic [1:0] sel_low          = 2'h3; // reload low byte
  localparam logic [7:0] unlock_first     = 8'h55;
  localparam logic [7:0] unlock_second    = 8'haa;

  // ************************************************************
  // reset cause register layout
  // ************************************************************
  localparam int cause_wdt_pos  = 5; // watchdog cause flag
  localparam int cause_stop_pos = 4; // stop-recovery flag
  localparam logic [7:0] cause_reset_value = 8'h00;

  // ************************************************************
  // counter and timing
  // ************************************************************
  localparam logic [23:0] reload_reset_value = 24'hffffff;
  localparam int  core_clk_mhz        = 100;
  localparam int  wdog_tick_ns        = 100; // watchdog clock period
  localparam int  tick_div_cycles     = (wdog_tick_ns * core_clk_mhz) / 1000;
  localparam logic [7:0] tick_div_last = 8'(tick_div_cycles - 1);

  // lock state machine
  typedef enum logic [2:0] {
    lock_idle     = 3'b000,
    lock_got_first = 3'b001,
    lock_open_upper = 3'b010,
    lock_open_high  = 3'b011,
    lock_open_low   = 3'b100
  } lock_state_type;

  // one register access, write or read, from the core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] sel;
    logic [7:0] data;
  } reg_req_type;

endpackage

// ==== sim/core_model.sv ====
// processor core model: register writes and reads, refresh, cause clear.
// assumes the bench calls its tasks; drives only at the falling edge.
`timescale 1ns/1ps
module core_model
  import wdog_pkg::*;
(
  input  wire logic  core_clk,    // system clock
  output reg_req_type req,        // register access to the watchdog
  output logic       refresh,     // refresh instruction pulse
  output logic       cause_clear  // reset cause clear pulse
);
  // ************************************************************
  // core side stimulus
  // ************************************************************
  // idle bus from time zero
  initial begin
    req = '0;
    refresh = 1'b0;
    cause_clear = 1'b0;
  end

  // one access, held across exactly one rising edge
  task automatic access(input logic is_rd, input logic [1:0] sel,
                        input logic [7:0] data);
    @(negedge core_clk);
    req <= '{wr: !is_rd, rd: is_rd, sel: sel, data: data};
    @(negedge core_clk);
    req <= '0;
  endtask

  // unlock, then upper, high, low, nothing else in between
  task automatic reload(input logic [23:0] val);
    access(1'b0, sel_control_port, unlock_first);
    access(1'b0, sel_control_port, unlock_second);
    access(1'b0, sel_upper, val[23:16]);
    access(1'b0, sel_high, val[15:8]);
    access(1'b0, sel_low, val[7:0]);
  endtask

  // one-cycle refresh (which=1) or cause clear (which=0)
  task automatic pulse(input logic which);
    @(negedge core_clk);
    if (which) refresh <= 1'b1;
    else cause_clear <= 1'b1;
    @(negedge core_clk);
    refresh <= 1'b0;
    cause_clear <= 1'b0;
  endtask
endmodule // core_model

// ==== sim/testbench.sv ====
// self-checking bench for the watchdog reset and reload lock.
// assumes core_model drives the register port; bench drives levels.
`timescale 1ns/1ps
module testbench
  import wdog_pkg::*;
;
  logic        core_clk, sys_rst, wdog_enable, reset_on_to, stop_mode;
  logic        refresh, cause_clear, sys_reset_req, stop_recover;
  logic        timeout_evt, rd_seen;
  logic [7:0]  rd_data, low;
  reg_req_type req;
  logic [7:0]  expq[$];
  int          n_errors = 0;
  int          samples_checked = 0;

  core_model core (.core_clk(core_clk), .req(req), .refresh(refresh),
                   .cause_clear(cause_clear));
  wdog_reload_lock i_wdog_reload_lock (.core_clk(core_clk),
    .sys_rst(sys_rst), .req(req), .wdog_enable(wdog_enable),
    .reset_on_to(reset_on_to), .stop_mode(stop_mode), .refresh(refresh),
    .cause_clear(cause_clear), .rd_data(rd_data),
    .sys_reset_req(sys_reset_req), .stop_recover(stop_recover),
    .timeout_evt(timeout_evt));

  // ************************************************************
  // clock, checking and reporting
  // ************************************************************
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // note the expected read value, then issue the read
  task automatic rd(input logic [1:0] sel, input logic [7:0] exp);
    expq.push_back(exp);
    core.access(1'b1, sel, 8'h00);
  endtask

  // wait for a timeout pulse up to lim cycles, check the reset outputs
  task automatic watch(input int lim, input logic hit, rst, stp);
    for (int i = 0; i < lim && timeout_evt !== 1'b1; i++)
      @(negedge core_clk);
    check("timeout_evt", {7'h0, timeout_evt === 1'b1}, {7'h0, hit});
    if (hit) begin
      check("sys_reset_req", {7'h0, sys_reset_req}, {7'h0, rst});
      check("stop_recover", {7'h0, stop_recover}, {7'h0, stp});
    end
  endtask

  // read monitor: data shows one cycle after the read was taken
  always @(posedge core_clk) rd_seen <= req.rd;
  always @(negedge core_clk)
    if (rd_seen === 1'b1)
      check("rd_data", rd_data, expq.pop_front());

  // hang guard, well beyond the few hundred cycles the tests need
  initial begin
    #(5000 * 10);
    n_errors++;
    $display("watchdog span expired");
    summarize();
  end

  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    int seed_ret;
    sys_rst = 1'b1;
    wdog_enable = 1'b0;
    reset_on_to = 1'b1;
    stop_mode = 1'b0;
    seed_ret = $urandom(32'h04de8b5e);
    repeat (10) @(negedge core_clk);
    sys_rst = 1'b0;
    rd(sel_control_port, cause_reset_value);
    core.access(1'b0, sel_control_port, unlock_first);
    rd(sel_control_port, cause_reset_value);
    $display("test reset done");
    // stray reload write, then a sequence broken by a foreign write
    core.access(1'b0, sel_low, 8'($urandom));
    core.access(1'b0, sel_control_port, unlock_first);
    core.access(1'b0, sel_control_port, unlock_second);
    core.access(1'b0, sel_upper, 8'h12);
    core.access(1'b0, sel_control_port, 8'h00);
    core.access(1'b0, sel_high, 8'h00);
    core.access(1'b0, sel_low, 8'h01);
    wdog_enable = 1'b1;
    watch(100, 1'b0, 1'b0, 1'b0);
    rd(sel_upper, 8'h12);
    rd(sel_high, 8'hff);
    wdog_enable = 1'b0;
    $display("test lock done");
    // proper reload, refresh keeps it alive, then normal reset
    low = 8'(4 + $urandom % 4);
    core.reload({16'h0000, low});
    wdog_enable = 1'b1;
    rd(sel_upper, 8'h00);
    repeat (6) begin
      core.pulse(1'b1);
      watch(10, 1'b0, 1'b0, 1'b0);
    end
    watch(120, 1'b1, 1'b1, 1'b0);
    wdog_enable = 1'b0;
    rd(sel_control_port, 8'(1 << cause_wdt_pos));
    $display("test normal reset done");
    // stop mode timeout gives recovery and both flags
    core.pulse(1'b0);
    stop_mode = 1'b1;
    wdog_enable = 1'b1;
    watch(120, 1'b1, 1'b0, 1'b1);
    wdog_enable = 1'b0;
    rd(sel_control_port,
       8'((1 << cause_wdt_pos) | (1 << cause_stop_pos)));
    $display("test stop recovery done");
    // timeout with reset disabled: pulse only, no flags
    core.pulse(1'b0);
    reset_on_to = 1'b0;
    stop_mode = 1'b0;
    wdog_enable = 1'b1;
    watch(120, 1'b1, 1'b0, 1'b0);
    wdog_enable = 1'b0;
    rd(sel_control_port, cause_reset_value);
    $display("test no reset done");
    // reset in mid-run: reload back to all ones, lock closed
    sys_rst = 1'b1;
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    core.access(1'b0, sel_upper, 8'h00);
    wdog_enable = 1'b1;
    rd(sel_upper, 8'hff);
    wdog_enable = 1'b0;
    $display("test mid-run reset done");
    summarize();
  end
endmodule // testbench

// ==== verilog/wdog_reload_lock.sv ====
// watchdog counter with reset-on-timeout and locked reload path.
// assumes byte writes from the core, one request per cycle, synchronous
// sys_rst, and a core-supplied refresh pulse and stop-mode level.
//
// Summary of operation
// - a timeout with reset enabled in normal run forces system reset.
// - such a timeout sets the watchdog cause flag to 1.
// - a timeout with reset enabled in stop mode starts stop recovery.
// - a stop-mode timeout with reset enabled sets both watchdog and stop flags to 1.
// - reload bytes stay protected until the unlock pattern completes.
// - unlock writes store nothing, they only advance the lock machine.
// - any stray write during the sequence returns the lock to start.
// - reload writes outside an opened sequence are ignored.
// - counter loads the reload on first enable and on every refresh while enabled.
// - control stores no written bits; reads there return the reset cause.
// - reload bytes form a 24-bit value; reads return the live count.
`timescale 1ns/1ps
module wdog_reload_lock
  import wdog_pkg::*;
(
  input  wire logic        core_clk,    // 100 mhz system clock
  input  wire logic        sys_rst,     // synchronous reset, high
  input  wire reg_req_type req,         // register access from core
  input  wire logic        wdog_enable, // watchdog enabled
  input  wire logic        reset_on_to, // timeout causes reset
  input  wire logic        stop_mode,   // device is in stop mode
  input  wire logic        refresh,     // refresh instruction pulse
  input  wire logic        cause_clear, // core clears reset cause
  output logic [7:0]       rd_data,     // read data, one cycle later
  output logic             sys_reset_req, // system reset pulse
  output logic             stop_recover,  // stop recovery pulse
  output logic             timeout_evt    // timeout pulse
);

  // every check below runs on the system clock, idle during reset
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  // ************************************************************
  // state
  // ************************************************************
  lock_state_type lock_state;
  lock_state_type next_lock_state;
  logic [23:0]    reload;
  logic [23:0]    count;
  logic [7:0]     cause;
  logic [7:0]     tick_cnt;
  logic           enabled_d;

  // ************************************************************
  // decode
  // ************************************************************
  wire ctl_wr    = req.wr && (req.sel == sel_control_port);
  wire wr_upper  = req.wr && (req.sel == sel_upper)
                   && (lock_state == lock_open_upper);
  wire wr_high   = req.wr && (req.sel == sel_high)
                   && (lock_state == lock_open_high);
  wire wr_low    = req.wr && (req.sel == sel_low)
                   && (lock_state == lock_open_low);
  wire tick      = (tick_cnt == tick_div_last);
  wire first_en  = wdog_enable && !enabled_d;
  wire load_now  = first_en || (wdog_enable && refresh);
  wire expire    = wdog_enable && tick && (count == 24'h000000)
                   && !load_now;
  wire to_reset  = expire && reset_on_to;
  wire to_normal = to_reset && !stop_mode;
  wire to_stop   = to_reset && stop_mode;

  // lock machine: only the exact next step advances, any other write resets
  always_comb begin
    next_lock_state = lock_state;
    if (req.wr) begin
      case (lock_state)
        lock_idle:
          next_lock_state = (ctl_wr && req.data == unlock_first)
                            ? lock_got_first : lock_idle;
        lock_got_first:
          next_lock_state = (ctl_wr && req.data == unlock_second)
                            ? lock_open_upper : lock_idle;
        lock_open_upper:
          next_lock_state = wr_upper ? lock_open_high : lock_idle;
        lock_open_high:
          next_lock_state = wr_high ? lock_open_low : lock_idle;
        lock_open_low:
          next_lock_state = lock_idle;
        default:
          next_lock_state = lock_idle;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) lock_state <= lock_idle;
    else lock_state <= next_lock_state;
  end

  // reload bytes; control writes store no bits at all
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reload <= reload_reset_value;
    end else begin
      if (wr_upper) reload[23:16] <= req.data;
      if (wr_high)  reload[15:8]  <= req.data;
      if (wr_low)   reload[7:0]   <= req.data;
    end
  end

  // watchdog tick divider
  always_ff @(posedge core_clk) begin
    if (sys_rst || tick) tick_cnt <= 8'h00;
    else tick_cnt <= tick_cnt + 8'h01;
  end

  // down counter
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      count     <= reload_reset_value;
      enabled_d <= 1'b0;
    end else begin
      enabled_d <= wdog_enable;
      if (load_now) count <= reload;
      else if (wdog_enable && tick && count != 24'h000000)
        count <= count - 24'h000001;
      else if (expire) count <= reload;
    end
  end

  // reset cause flags; hardware set wins over software clear
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cause <= cause_reset_value;
    end else begin
      if (cause_clear) cause <= cause_reset_value;
      if (to_normal) cause[cause_wdt_pos] <= 1'b1;
      if (to_stop) begin
        cause[cause_wdt_pos]  <= 1'b1;
        cause[cause_stop_pos] <= 1'b1;
      end
    end
  end

  // registered outputs
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rd_data       <= 8'h00;
      sys_reset_req <= 1'b0;
      stop_recover  <= 1'b0;
      timeout_evt   <= 1'b0;
    end else begin
      sys_reset_req <= to_normal;
      stop_recover  <= to_stop;
      timeout_evt   <= expire;
      case (req.sel)
        sel_control_port: rd_data <= cause;
        sel_upper:        rd_data <= count[23:16];
        sel_high:         rd_data <= count[15:8];
        sel_low:          rd_data <= count[7:0];
        default:          rd_data <= 8'h00;
      endcase
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  // reset and timeout outputs
  chk_reset_pulse: assert property (
    to_normal |=> sys_reset_req && !stop_recover)
    else $error("normal timeout did not request reset");
  chk_wdt_flag: assert property (
    to_normal |=> cause[cause_wdt_pos])
    else $error("watchdog flag not set");
  chk_stop_path: assert property (
    to_stop |=> stop_recover && !sys_reset_req)
    else $error("stop timeout did not start recovery");
  chk_stop_flags: assert property (
    to_stop |=> cause[cause_wdt_pos] && cause[cause_stop_pos])
    else $error("stop timeout flags not set");
  chk_expire_pulse: assert property (
    expire |=> timeout_evt)
    else $error("expired count gave no timeout pulse");
  chk_no_reset_cfg: assert property (
    (expire && !reset_on_to) |=> !sys_reset_req && !stop_recover)
    else $error("timeout caused reset while reset disabled");

  // lock and reload path
  chk_locked_write: assert property (
    (req.wr && req.sel != sel_control_port && lock_state == lock_idle)
      |=> $stable(reload))
    else $error("reload changed while locked");
  chk_stray_relock: assert property (
    (lock_state == lock_open_high && req.wr && req.sel != sel_high)
      |=> lock_state == lock_idle)
    else $error("stray write did not relock");
  chk_unlock_open: assert property (
    (lock_state == lock_got_first && ctl_wr && req.data == unlock_second)
      |=> lock_state == lock_open_upper)
    else $error("unlock pattern did not open reload");
  chk_ctl_nostore: assert property (
    ctl_wr |=> $stable(reload))
    else $error("control write changed reload");
  chk_reload_guard: assert property (
    (lock_state == lock_idle || lock_state == lock_got_first)
      |=> $stable(reload))
    else $error("reload changed before unlock completed");
  chk_high_refused: assert property (
    (req.wr && req.sel == sel_high && lock_state != lock_open_high)
      |=> $stable(reload[15:8]))
    else $error("high reload byte written out of order");
  chk_upper_accept: assert property (
    wr_upper |=> reload[23:16] == $past(req.data))
    else $error("upper reload byte not stored");
  chk_low_closes: assert property (
    (lock_state == lock_open_low && req.wr) |=> lock_state == lock_idle)
    else $error("lock not closed after last reload byte");

  // counter and read-back
  chk_refresh_load: assert property (
    (wdog_enable && refresh) |=> count == $past(reload))
    else $error("refresh did not load counter");
  chk_first_load: assert property (
    first_en |=> count == $past(reload))
    else $error("first enable did not load counter");
  chk_count_step: assert property (
    (wdog_enable && tick && !load_now && count != 24'h000000)
      |=> count == $past(count) - 24'h000001)
    else $error("counter did not step down on tick");
  chk_cause_read: assert property (
    req.sel == sel_control_port |=> rd_data == $past(cause))
    else $error("control address did not read reset cause");
  chk_count_read: assert property (
    req.sel == sel_low |=> rd_data == $past(count[7:0]))
    else $error("low byte read did not return live count");

endmodule // wdog_reload_lock
